/* core/pwmdb_pkg.sv */
package pwmdb_pkg;
	// Widths
	localparam int CNT_W = 16;
	localparam int DB_W = 12;
	localparam int NUM_EV = 6;
	localparam int ACT_W = 2;
	localparam int ADDR_W = 8;
	// Register byte offsets
	localparam logic [ADDR_W-1:0] REG_UPD = 8'h00;
	localparam logic [ADDR_W-1:0] REG_SYNC = 8'h04;
	localparam logic [ADDR_W-1:0] REG_OUTEN = 8'h08;
	localparam logic [ADDR_W-1:0] REG_INV = 8'h0C;
	localparam logic [ADDR_W-1:0] REG_FLTEN = 8'h10;
	localparam logic [ADDR_W-1:0] REG_GCTL = 8'h14;
	localparam logic [ADDR_W-1:0] REG_INTEN = 8'h18;
	localparam logic [ADDR_W-1:0] REG_COUNT = 8'h1C;
	localparam logic [ADDR_W-1:0] REG_LOAD = 8'h20;
	localparam logic [ADDR_W-1:0] REG_CMPA = 8'h24;
	localparam logic [ADDR_W-1:0] REG_CMPB = 8'h28;
	localparam logic [ADDR_W-1:0] REG_ACTA = 8'h2C;
	localparam logic [ADDR_W-1:0] REG_ACTB = 8'h30;
	localparam logic [ADDR_W-1:0] REG_DBCTL = 8'h34;
	localparam logic [ADDR_W-1:0] REG_DBRISE = 8'h38;
	localparam logic [ADDR_W-1:0] REG_DBFALL = 8'h3C;
	localparam logic [ADDR_W-1:0] REG_STATUS = 8'h40;
	// Generator control field positions
	localparam int GCTL_RUN = 0;
	localparam int GCTL_UPDN = 1;
	localparam int GCTL_STALLRUN = 2;
	localparam int GCTL_SYNCUPD = 3;
	localparam int GCTL_W = 4;
	// Event positions; interrupt enable uses the same order plus the fault bit
	localparam int EV_ZERO = 0;
	localparam int EV_LOAD = 1;
	localparam int EV_AUP = 2;
	localparam int EV_ADN = 3;
	localparam int EV_BUP = 4;
	localparam int EV_BDN = 5;
	localparam int INTEN_FAULT = 6;
	// Status field positions
	localparam int ST_FAULT = 0;
	localparam int ST_DIR = 1;
	localparam int ST_GENA = 2;
	localparam int ST_GENB = 3;
	// Action codes
	localparam logic [ACT_W-1:0] ACT_NONE = 2'h0;
	localparam logic [ACT_W-1:0] ACT_TOGGLE = 2'h1;
	localparam logic [ACT_W-1:0] ACT_LOW = 2'h2;
	localparam logic [ACT_W-1:0] ACT_HIGH = 2'h3;

	typedef enum logic {PWMDB_DOWN, PWMDB_UP} pwmdb_dir_type;

	function automatic logic act_apply(input logic cur, input logic [ACT_W-1:0] code);
		logic r;
		r = cur;
		unique case (code)
			ACT_NONE: r = cur;
			ACT_TOGGLE: r = !cur;
			ACT_LOW: r = 1'b0;
			ACT_HIGH: r = 1'b1;
		endcase
		return r;
	endfunction

	// One generator output; own_a selects which comparator wins a tie
	function automatic logic gen_step(input logic cur, input logic [NUM_EV*ACT_W-1:0] acts,
		input logic [NUM_EV-1:0] ev, input logic own_a);
		logic v;
		logic ma;
		logic mb;
		v = cur;
		ma = ev[EV_AUP] | ev[EV_ADN];
		mb = ev[EV_BUP] | ev[EV_BDN];
		if (ev[EV_ZERO]) begin
			v = act_apply(v, acts[EV_ZERO*ACT_W +: ACT_W]);
		end
		if (ev[EV_LOAD]) begin
			v = act_apply(v, acts[EV_LOAD*ACT_W +: ACT_W]);
		end
		if (!(ev[EV_ZERO] | ev[EV_LOAD])) begin
			if (ma && (own_a || !mb)) begin
				v = act_apply(v, ev[EV_AUP] ? acts[EV_AUP*ACT_W +: ACT_W]
					: acts[EV_ADN*ACT_W +: ACT_W]);
			end
			if (mb && (!own_a || !ma)) begin
				v = act_apply(v, ev[EV_BUP] ? acts[EV_BUP*ACT_W +: ACT_W]
					: acts[EV_BDN*ACT_W +: ACT_W]);
			end
		end
		return v;
	endfunction

	function automatic logic [31:0] be_merge(input logic [31:0] cur, input logic [31:0] wd,
		input logic [3:0] be);
		logic [31:0] r;
		r = cur;
		for (int i = 0; i < 4; i++) begin
			if (be[i]) begin
				r[8*i +: 8] = wd[8*i +: 8];
			end
		end
		return r;
	endfunction
endpackage

/* core/pwmdb_evt_if.sv */
`timescale 1ns/1ps
interface pwmdb_evt_if;
	import pwmdb_pkg::*;
	logic [CNT_W-1:0] count;
	logic dir;
	logic at_zero;
	logic [NUM_EV-1:0] ev;
	modport src (output count, output dir, output at_zero, output ev);
	modport dst (input count, input dir, input at_zero, input ev);
endinterface

/* core/pwmdb_counter.sv */
`timescale 1ns/1ps
module pwmdb_counter import pwmdb_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Control
	input wire logic run_i,
	input wire logic updown_i,
	input wire logic stall_i,
	input wire logic stall_run_i,
	input wire logic sync_i,
	input wire logic [CNT_W-1:0] load_i,
	input wire logic [CNT_W-1:0] cmpa_i,
	input wire logic [CNT_W-1:0] cmpb_i,
	// Events
	pwmdb_evt_if.src evt
);
	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		pwmdb_dir_type dir;
	} pwmdb_cnt_type;

	pwmdb_cnt_type q;
	pwmdb_cnt_type d;
	logic adv;
	logic ma;
	logic mb;
	logic up_phase;

	// A stall without run-on freezes the count once it sits at zero
	assign adv = run_i && !(stall_i && !stall_run_i && q.cnt == '0);
	assign up_phase = updown_i && q.dir == PWMDB_UP;
	// A match value above the load value can never be met
	assign ma = adv && q.cnt == cmpa_i && cmpa_i <= load_i;
	assign mb = adv && q.cnt == cmpb_i && cmpb_i <= load_i;

	always_comb begin
		d = q;
		if (sync_i) begin
			d.cnt = '0;
			d.dir = PWMDB_UP;
		end else if (adv) begin
			if (!updown_i) begin
				d.dir = PWMDB_DOWN;
				d.cnt = (q.cnt == '0) ? load_i : q.cnt - 16'h1;
			end else begin
				unique case (q.dir)
					PWMDB_UP: begin
						if (q.cnt >= load_i) begin
							d.dir = PWMDB_DOWN;
							d.cnt = (q.cnt == '0) ? q.cnt : q.cnt - 16'h1;
						end else begin
							d.cnt = q.cnt + 16'h1;
						end
					end
					PWMDB_DOWN: begin
						if (q.cnt == '0) begin
							d.dir = PWMDB_UP;
							d.cnt = (load_i == '0) ? q.cnt : q.cnt + 16'h1;
						end else begin
							d.cnt = q.cnt - 16'h1;
						end
					end
				endcase
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign evt.count = q.cnt;
	assign evt.dir = up_phase;
	assign evt.at_zero = q.cnt == '0;
	assign evt.ev[EV_ZERO] = adv && q.cnt == '0;
	assign evt.ev[EV_LOAD] = adv && q.cnt == load_i;
	assign evt.ev[EV_AUP] = ma && up_phase;
	assign evt.ev[EV_ADN] = ma && !up_phase;
	assign evt.ev[EV_BUP] = mb && up_phase;
	assign evt.ev[EV_BDN] = mb && !up_phase;
endmodule

/* core/pwmdb_deadband.sv */
`timescale 1ns/1ps
module pwmdb_deadband import pwmdb_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Settings
	input wire logic enable_i,
	input wire logic [DB_W-1:0] rise_i,
	input wire logic [DB_W-1:0] fall_i,
	// Signals
	input wire logic in_a_i,
	input wire logic in_b_i,
	output logic out_a_o,
	output logic out_b_o
);
	typedef struct packed {
		logic prev;
		logic busy;
		logic [DB_W-1:0] cnt;
		logic oa;
		logic ob;
	} pwmdb_db_type;

	pwmdb_db_type q;
	pwmdb_db_type d;

	always_comb begin
		d = q;
		if (!enable_i) begin
			d.oa = in_a_i;
			d.ob = in_b_i;
			// Seen as an edge on enabling, so both outputs start from a dead phase
			d.prev = !in_a_i;
			d.busy = 1'b0;
		end else if (in_a_i != q.prev) begin
			d.prev = in_a_i;
			d.oa = 1'b0;
			d.ob = 1'b0;
			d.cnt = in_a_i ? rise_i : fall_i;
			d.busy = 1'b1;
		end else if (q.busy) begin
			if (q.cnt == '0) begin
				d.oa = q.prev;
				d.ob = !q.prev;
				d.busy = 1'b0;
			end else begin
				d.cnt = q.cnt - 12'h1;
			end
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign out_a_o = q.oa;
	assign out_b_o = q.ob;
endmodule

/* core/pwmdb_top.sv */
`timescale 1ns/1ps
// Summary of operation
// - One 16-bit counter, down or up/down.
// - Down mode: count load to zero, reload, continue; zero then load.
// - Up/down mode: zero up to load, back down to zero, repeat.
// - Direction low in down mode; high counting up in up/down mode.
// - One-cycle pulses at count zero and at count equal to load.
// - Two comparators pulse on match, split by direction in up/down mode.
// - Match value above load never matches.
// - Four events in down mode, six in up/down mode.
// - Matches coinciding with zero or load are ignored by the generator.
// - On simultaneous matches, output A follows A only, B follows B only.
// - Each event applies none, toggle, low or high per output.
// - Dead band off: both generator signals pass unchanged.
// - Dead band on: output A is signal A with delayed rising edge.
// - Dead band on: output B is inverted A, rising edge delayed after fall.
// - Any subset of events may raise the interrupt.
// - Interrupt uses raw events, not dead-band delayed edges.
// - Global reset request returns the counter to its start.
// - Immediate mode: new load and compare apply at next zero.
// - Sync mode: new values wait for update request, then next zero.
// - Per-output fault enable forces output inactive; fault may interrupt.
// - Stall stops at zero or keeps running; stall never interrupts.
// - One enable mask and one inversion mask for the outputs.
// - Disabled outputs become zero, still passing through inversion.
// - Sync bit resets counter to zero and self-clears when done.
module pwmdb_top import pwmdb_pkg::*; (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic reset_i,
	// Avalon-MM slave
	input wire logic [ADDR_W-1:0] avs_address_i,
	input wire logic avs_read_i,
	input wire logic avs_write_i,
	input wire logic [31:0] avs_writedata_i,
	input wire logic [3:0] avs_byteenable_i,
	output logic [31:0] avs_readdata_o,
	output logic avs_waitrequest_o,
	// External conditions
	input wire logic fault_i,
	input wire logic stall_i,
	// Pins and interrupt
	output logic pin_output_zero_o,
	output logic pin_output_one_o,
	output logic irq_o
);
	typedef struct packed {
		logic ack;
		logic [31:0] rdata;
		logic upd_req;
		logic sync_req;
		logic [1:0] outen;
		logic [1:0] inv;
		logic [1:0] flten;
		logic [GCTL_W-1:0] gctl;
		logic [NUM_EV:0] inten;
		logic [CNT_W-1:0] load_p;
		logic [CNT_W-1:0] cmpa_p;
		logic [CNT_W-1:0] cmpb_p;
		logic [CNT_W-1:0] load_a;
		logic [CNT_W-1:0] cmpa_a;
		logic [CNT_W-1:0] cmpb_a;
		logic [NUM_EV*ACT_W-1:0] acta;
		logic [NUM_EV*ACT_W-1:0] actb;
		logic db_en;
		logic [DB_W-1:0] rise;
		logic [DB_W-1:0] fall;
		logic gen_a;
		logic gen_b;
		logic flt_m;
		logic flt_s;
		logic flt_prev;
		logic stl_m;
		logic stl_s;
		logic pin0;
		logic pin1;
		logic irq;
	} pwmdb_top_type;

	pwmdb_top_type q;
	pwmdb_top_type d;
	pwmdb_evt_if evt ();
	logic req;
	logic wr;
	logic [31:0] rdv;
	logic [31:0] wv;
	logic db_a;
	logic db_b;
	logic sync_mode;
	logic ma;
	logic mb;

	pwmdb_counter u_counter (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.run_i(q.gctl[GCTL_RUN]),
		.updown_i(q.gctl[GCTL_UPDN]),
		.stall_i(q.stl_s),
		.stall_run_i(q.gctl[GCTL_STALLRUN]),
		.sync_i(q.sync_req),
		.load_i(q.load_a),
		.cmpa_i(q.cmpa_a),
		.cmpb_i(q.cmpb_a),
		.evt(evt.src)
	);

	pwmdb_deadband u_deadband (
		.core_clk_i(core_clk_i),
		.reset_i(reset_i),
		.enable_i(q.db_en),
		.rise_i(q.rise),
		.fall_i(q.fall),
		.in_a_i(q.gen_a),
		.in_b_i(q.gen_b),
		.out_a_o(db_a),
		.out_b_o(db_b)
	);

	// One wait state: read data is latched in the first cycle of a request
	assign req = avs_read_i | avs_write_i;
	assign wr = avs_write_i & q.ack;
	assign avs_waitrequest_o = req & !q.ack;
	assign avs_readdata_o = q.rdata;
	assign sync_mode = q.gctl[GCTL_SYNCUPD];
	assign ma = evt.ev[EV_AUP] | evt.ev[EV_ADN];
	assign mb = evt.ev[EV_BUP] | evt.ev[EV_BDN];
	assign wv = be_merge(rdv, avs_writedata_i, avs_byteenable_i);

	// Load and compare read back the pending values software last wrote
	always_comb begin
		rdv = '0;
		case (avs_address_i)
			REG_UPD: rdv = 32'(q.upd_req);
			REG_SYNC: rdv = 32'(q.sync_req);
			REG_OUTEN: rdv = 32'(q.outen);
			REG_INV: rdv = 32'(q.inv);
			REG_FLTEN: rdv = 32'(q.flten);
			REG_GCTL: rdv = 32'(q.gctl);
			REG_INTEN: rdv = 32'(q.inten);
			REG_COUNT: rdv = 32'(evt.count);
			REG_LOAD: rdv = 32'(q.load_p);
			REG_CMPA: rdv = 32'(q.cmpa_p);
			REG_CMPB: rdv = 32'(q.cmpb_p);
			REG_ACTA: rdv = 32'(q.acta);
			REG_ACTB: rdv = 32'(q.actb);
			REG_DBCTL: rdv = 32'(q.db_en);
			REG_DBRISE: rdv = 32'(q.rise);
			REG_DBFALL: rdv = 32'(q.fall);
			REG_STATUS: begin
				rdv[ST_FAULT] = q.flt_s;
				rdv[ST_DIR] = evt.dir;
				rdv[ST_GENA] = q.gen_a;
				rdv[ST_GENB] = q.gen_b;
			end
			default: rdv = '0;
		endcase
	end

	always_comb begin
		d = q;
		d.ack = req & !q.ack;
		if (req & !q.ack) begin
			d.rdata = rdv;
		end
		d.flt_m = fault_i;
		d.flt_s = q.flt_m;
		d.flt_prev = q.flt_s;
		d.stl_m = stall_i;
		d.stl_s = q.stl_m;
		// Auto-clears come first so a write in the same cycle wins
		if (q.sync_req) begin
			d.sync_req = 1'b0;
		end
		// Applying only at zero avoids runt or stretched pulses
		if (evt.at_zero && (!sync_mode || q.upd_req)) begin
			d.load_a = q.load_p;
			d.cmpa_a = q.cmpa_p;
			d.cmpb_a = q.cmpb_p;
			d.upd_req = 1'b0;
		end
		// Events of the unused direction never fire in down mode
		d.gen_a = gen_step(q.gen_a, q.acta, evt.ev, 1'b1);
		d.gen_b = gen_step(q.gen_b, q.actb, evt.ev, 1'b0);
		d.pin0 = (db_a & q.outen[0] & !(q.flt_s & q.flten[0])) ^ q.inv[0];
		d.pin1 = (db_b & q.outen[1] & !(q.flt_s & q.flten[1])) ^ q.inv[1];
		d.irq = |(evt.ev & q.inten[NUM_EV-1:0]);
		if (q.inten[INTEN_FAULT] && q.flt_s && !q.flt_prev) begin
			d.irq = 1'b1;
		end
		if (wr) begin
			case (avs_address_i)
				REG_UPD: begin
					if (wv[0]) begin
						d.upd_req = 1'b1;
					end
				end
				REG_SYNC: begin
					if (wv[0]) begin
						d.sync_req = 1'b1;
					end
				end
				REG_OUTEN: d.outen = wv[1:0];
				REG_INV: d.inv = wv[1:0];
				REG_FLTEN: d.flten = wv[1:0];
				REG_GCTL: d.gctl = wv[GCTL_W-1:0];
				REG_INTEN: d.inten = wv[NUM_EV:0];
				REG_LOAD: d.load_p = wv[CNT_W-1:0];
				REG_CMPA: d.cmpa_p = wv[CNT_W-1:0];
				REG_CMPB: d.cmpb_p = wv[CNT_W-1:0];
				REG_ACTA: d.acta = wv[NUM_EV*ACT_W-1:0];
				REG_ACTB: d.actb = wv[NUM_EV*ACT_W-1:0];
				REG_DBCTL: d.db_en = wv[0];
				REG_DBRISE: d.rise = wv[DB_W-1:0];
				REG_DBFALL: d.fall = wv[DB_W-1:0];
				default: d.db_en = q.db_en;
			endcase
		end
	end

	always_ff @(posedge core_clk_i or posedge reset_i) begin
		if (reset_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

	assign pin_output_zero_o = q.pin0;
	assign pin_output_one_o = q.pin1;
	assign irq_o = q.irq;

	default clocking cb @(posedge core_clk_i);
	endclocking
	default disable iff (reset_i);

	sequence s_cnt_cleared;
		evt.count == 16'h0 && !evt.dir;
	endsequence

	sequence s_sync_settled;
		!q.sync_req ##1 s_cnt_cleared;
	endsequence

	property p_sync_clear;
		q.sync_req && !(wr && avs_address_i == REG_SYNC) && !q.gctl[GCTL_RUN]
			|=> s_sync_settled;
	endproperty
	a_sync_clear: assert property (p_sync_clear) else $error("sync did not clear counter");

	property p_zero_single;
		evt.ev[EV_ZERO] && q.load_a != 16'h0 && !q.sync_req |=> !evt.ev[EV_ZERO];
	endproperty
	a_zero_single: assert property (p_zero_single) else $error("zero pulse too long");

	property p_down_reload;
		!q.gctl[GCTL_UPDN] && evt.ev[EV_ZERO] && !q.sync_req
			|=> evt.count == $past(q.load_a) && !evt.dir;
	endproperty
	a_down_reload: assert property (p_down_reload) else $error("no reload after zero");

	property p_cmp_above_load;
		q.cmpa_a > q.load_a |-> !ma;
	endproperty
	a_cmp_above_load: assert property (p_cmp_above_load) else $error("match above load");

	property p_ignore_at_zero;
		(evt.ev[EV_ZERO] || evt.ev[EV_LOAD]) && q.acta[3:0] == 4'h0 |=> $stable(q.gen_a);
	endproperty
	a_ignore_at_zero: assert property (p_ignore_at_zero) else $error("match acted at zero");

	property p_tie_split;
		ma && mb && !evt.ev[EV_ZERO] && !evt.ev[EV_LOAD] && q.acta[7:4] == 4'h0
			|=> $stable(q.gen_a);
	endproperty
	a_tie_split: assert property (p_tie_split) else $error("output A took B match");

	property p_action_high;
		evt.ev[EV_ZERO] && !evt.ev[EV_LOAD] && q.acta[1:0] == ACT_HIGH |=> q.gen_a;
	endproperty
	a_action_high: assert property (p_action_high) else $error("drive high not applied");

	property p_db_pass;
		!q.db_en |=> db_a == $past(q.gen_a) && db_b == $past(q.gen_b);
	endproperty
	a_db_pass: assert property (p_db_pass) else $error("dead band altered signals");

	property p_db_rise_late;
		q.db_en && $rose(q.gen_a) |=> !db_a && !db_b;
	endproperty
	a_db_rise_late: assert property (p_db_rise_late) else $error("rising edge not delayed");

	property p_db_no_overlap;
		q.db_en && $past(q.db_en) |-> !(db_a && db_b);
	endproperty
	a_db_no_overlap: assert property (p_db_no_overlap) else $error("outputs overlap");

	property p_irq_event;
		|(evt.ev & q.inten[NUM_EV-1:0]) |=> q.irq;
	endproperty
	a_irq_event: assert property (p_irq_event) else $error("enabled event lost");

	property p_imm_update;
		!sync_mode && evt.at_zero |=> q.load_a == $past(q.load_p);
	endproperty
	a_imm_update: assert property (p_imm_update) else $error("immediate update missed");

	property p_sync_hold;
		sync_mode && !q.upd_req |=> $stable(q.load_a) && $stable(q.cmpa_a);
	endproperty
	a_sync_hold: assert property (p_sync_hold) else $error("update without request");

	property p_fault_force;
		q.flt_s && q.flten[0] |=> q.pin0 == $past(q.inv[0]);
	endproperty
	a_fault_force: assert property (p_fault_force) else $error("fault did not force pin");

	property p_disabled_pin;
		!q.outen[1] |=> q.pin1 == $past(q.inv[1]);
	endproperty
	a_disabled_pin: assert property (p_disabled_pin) else $error("disabled pin not idle");
endmodule

/* tb/pwmdb_stage_model.sv */
`timescale 1ns/1ps
module pwmdb_stage_model (
	// Clock
	input wire logic core_clk_i,
	// Gate drives of one half bridge
	input wire logic high_gate_i,
	input wire logic low_gate_i,
	input wire logic armed_i,
	// Count of cycles with both switches on
	output int shoot_o
);
	int shoot_count = 0;
	// Both switches on shorts the supply, so every such cycle while armed is counted
	always @(posedge core_clk_i) begin
		if (armed_i && high_gate_i && low_gate_i) begin
			shoot_count <= shoot_count + 1;
		end
	end
	assign shoot_o = shoot_count;
endmodule

/* tb/pwmdb_top_tb.sv */
`timescale 1ns/1ps
module pwmdb_top_tb;
	import pwmdb_pkg::*;
	logic core_clk_i, reset_i, avs_read_i, avs_write_i, fault_i, stall_i, db_on;
	logic [ADDR_W-1:0] avs_address_i;
	logic [31:0] avs_writedata_i, avs_readdata_o, q;
	logic [3:0] avs_byteenable_i;
	logic avs_waitrequest_o, pin_output_zero_o, pin_output_one_o, irq_o;
	int errors, comparisons, cycles, shoot, hi, per, w1, v1, c;
	int ld, ca;
	logic [1:0] iv;
	pwmdb_top u_pwmdb_top(.core_clk_i(core_clk_i), .reset_i(reset_i),
		.avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
		.avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
		.avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
		.fault_i(fault_i), .stall_i(stall_i), .pin_output_zero_o(pin_output_zero_o),
		.pin_output_one_o(pin_output_one_o), .irq_o(irq_o));
	pwmdb_stage_model u_pwmdb_stage_model(.core_clk_i(core_clk_i),
		.high_gate_i(pin_output_zero_o), .low_gate_i(pin_output_one_o), .armed_i(db_on),
		.shoot_o(shoot));
	initial begin
		core_clk_i = 1'b0;
		forever #5 core_clk_i = !core_clk_i;
	end
	task automatic print_verdict();
		$display("errors=%0d comparisons=%0d", errors, comparisons);
		if (errors == 0 && comparisons > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	always @(posedge core_clk_i) begin
		cycles++;
		if (cycles >= 60000) begin
			errors++;
			print_verdict();
		end
	end
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			errors++;
			$display("ERROR %s expected %0h seen %0h", what, exp, got);
		end
	endtask
	// Request held until waitrequest is sampled low; data taken at that edge
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk_i);
		avs_address_i <= a;
		avs_writedata_i <= d;
		avs_write_i <= wr;
		avs_read_i <= !wr;
		do begin
			@(posedge core_clk_i);
			n++;
		end while (avs_waitrequest_o !== 1'b0 && n < 50);
		q = avs_readdata_o;
		avs_write_i <= 1'b0;
		avs_read_i <= 1'b0;
		if (n >= 50) errors++;
	endtask
	task automatic wait_lvl(input bit b, input logic v, inout int cnt);
		int n;
		n = 0;
		while ((b ? pin_output_one_o : pin_output_zero_o) !== v && n < 4000) begin
			@(negedge core_clk_i);
			cnt++;
			n++;
		end
		if (n >= 4000) errors++;
	endtask
	// High time and period of one pin, from one rising edge to the next
	task automatic measure(input bit b);
		hi = 0;
		wait_lvl(b, 1'b0, hi);
		wait_lvl(b, 1'b1, hi);
		hi = 0;
		wait_lvl(b, 1'b0, hi);
		per = hi;
		wait_lvl(b, 1'b1, per);
	endtask
	task automatic count_irq(input int n);
		c = 0;
		repeat (n) begin
			@(negedge core_clk_i);
			if (irq_o === 1'b1) c++;
		end
	endtask
	// Reference model: high time of output A for the programmed shape
	function automatic int exp_hi(input bit updn, input int load, input int cmp);
		return updn ? 2 * (load - cmp) : load - cmp + 1;
	endfunction
	task automatic shape(input bit updn, input int load, input int cmp);
		bus(1, REG_LOAD, load);
		bus(1, REG_CMPA, cmp);
		measure(0);
		measure(0);
		check("period", updn ? 2 * load : load + 1, per);
		check("high time", exp_hi(updn, load, cmp), hi);
	endtask
	initial begin
		{errors, comparisons, cycles, db_on} = '0;
		{avs_read_i, avs_write_i, fault_i, stall_i} = '0;
		avs_address_i = '0;
		avs_writedata_i = '0;
		avs_byteenable_i = 4'hF;
		reset_i = 1'b1;
		void'($urandom(32'h2b1a27c9));
		repeat (4) @(posedge core_clk_i);
		reset_i <= 1'b0;
		for (int a = 0; a <= 8'h44; a += 4) begin
			bus(0, a[7:0], 32'h0);
			check("reset value", 32'h0, q);
		end
		bus(1, 8'h44, 32'hFFFFFFFF);
		bus(0, 8'h44, 32'h0);
		check("unmapped", 32'h0, q);
		bus(1, REG_ACTA, {24'h0, ACT_LOW, 4'h0, ACT_HIGH});
		bus(1, REG_OUTEN, 32'h3);
		bus(1, REG_GCTL, 32'h1);
		for (int i = 0; i < 3; i++) begin
			ld = 8 + $urandom % 40;
			ca = 1 + $urandom % (ld - 1);
			shape(0, ld, ca);
		end
		bus(1, REG_ACTA, {24'h0, ACT_LOW, ACT_HIGH, 4'h0});
		bus(1, REG_ACTB, {22'h0, ACT_HIGH, 8'h0});
		bus(1, REG_GCTL, 32'h3);
		for (int i = 0; i < 3; i++) begin
			ld = 8 + $urandom % 40;
			ca = 1 + $urandom % (ld - 1);
			// Above every load picked here, so B stays silent even while a new load waits
			bus(1, REG_CMPB, 48);
			shape(1, ld, ca);
			count_irq(2 * ld);
			check("unmatched B", 32'h0, {31'h0, pin_output_one_o});
		end
		bus(1, REG_INTEN, 32'h1);
		count_irq(20 * ld);
		check("zero irq count", 10, c);
		bus(1, REG_INTEN, 32'h3);
		count_irq(20 * ld);
		check("zero and load irq count", 20, c);
		bus(1, REG_LOAD, 40);
		bus(1, REG_CMPA, 20);
		// B matches on the same count as A from here on, so every match is a tie
		bus(1, REG_CMPB, 20);
		bus(1, REG_ACTB, {20'h0, ACT_HIGH, ACT_LOW, 8'h0});
		bus(1, REG_DBCTL, 32'h1);
		db_on = 1'b1;
		bus(1, REG_DBRISE, 2);
		bus(1, REG_DBFALL, 5);
		measure(0);
		measure(0);
		w1 = hi;
		check("dead band period", 80, per);
		measure(1);
		v1 = hi;
		bus(1, REG_DBRISE, 6);
		bus(1, REG_DBFALL, 9);
		measure(0);
		measure(0);
		check("rise delay effect", 4, w1 - hi);
		measure(1);
		check("fall delay effect", 4, v1 - hi);
		check("both gates on", 0, shoot);
		db_on = 1'b0;
		bus(1, REG_DBCTL, 32'h0);
		bus(1, REG_GCTL, 32'hB);
		bus(1, REG_LOAD, 30);
		measure(0);
		measure(0);
		check("held load", 80, per);
		check("tie high time", exp_hi(1, 40, 20), hi);
		bus(1, REG_UPD, 32'h1);
		measure(0);
		measure(0);
		check("updated load", 60, per);
		check("updated high time", exp_hi(1, 30, 20), hi);
		bus(1, REG_GCTL, 32'h0);
		bus(1, REG_SYNC, 32'h1);
		bus(0, REG_SYNC, 32'h0);
		check("sync bit", 32'h0, q);
		bus(0, REG_COUNT, 32'h0);
		check("count after sync", 32'h0, q);
		for (int i = 0; i < 4; i++) begin
			iv = 2'($urandom);
			bus(1, REG_OUTEN, 32'h0);
			bus(1, REG_INV, {30'h0, iv});
			// Pins are registered, so the new polarity shows a cycle after the write
			repeat (2) @(negedge core_clk_i);
			check("idle pins", iv, {pin_output_one_o, pin_output_zero_o});
			bus(1, REG_OUTEN, 32'h3);
			bus(1, REG_FLTEN, 32'h3);
			bus(1, REG_INTEN, 32'h40);
			fault_i <= 1'b1;
			count_irq(8);
			check("fault irq", 1, c);
			check("fault pins", iv, {pin_output_one_o, pin_output_zero_o});
			bus(1, REG_FLTEN, 32'h0);
			fault_i <= 1'b0;
		end
		bus(1, REG_INV, 32'h0);
		bus(1, REG_INTEN, 32'h3F);
		bus(1, REG_GCTL, 32'h3);
		stall_i <= 1'b1;
		repeat (100) @(posedge core_clk_i);
		bus(0, REG_COUNT, 32'h0);
		check("stalled count", 32'h0, q);
		count_irq(100);
		check("stall irq", 0, c);
		bus(1, REG_INTEN, 32'h1);
		bus(1, REG_GCTL, 32'h7);
		count_irq(600);
		check("run-on zero irq count", 10, c);
		@(posedge core_clk_i);
		stall_i <= 1'b0;
		print_verdict();
	end
endmodule
